// ===== logic/nibble_bus_flash_port_control.sv
// protocol control for the clocked 4-bit multiplexed host bus
// What this block does
// R01 - decode only low five address nibbles
// R02 - small density also ignores bit 19
// R03 - bit 22 selects core or registers
// R04 - nonzero size: go idle, no response
// R05 - unaligned multibyte read: first exact, rest aligned
// R06 - after valid header, accept all nibbles
// R07 - pass command bytes unchecked to core
// R08 - framing strobe low: float bus, reset
// R09 - strobe never aborts running core operation
// R10 - commit write only after last data nibble
// R11 - act on write data before sync
// R12 - host holds reset long after power
// R13 - respond only when id matches straps
// R14 - take last start nibble before strobe rises
// R15 - host sends data low nibble first
// R16 - ready sync for one clock after write
// R17 - after reset float outputs, wait idle
module nibble_bus_flash_port_control #(
  parameter bit SMALL_DENSITY = 1'b0,          // 1 selects the smaller density
  parameter int READ_BYTES = 1                 // bytes per read, one supported
) (
  input wire logic clock,                      // bus clock
  input wire logic sys_rst,                    // synchronous reset, active high
  input wire logic frame_strobe_n,             // framing strobe, active low
  input wire logic [3:0] nibble_bus_in,        // nibble bus as sampled
  output logic [3:0] nibble_bus_out,           // nibble bus drive value
  output logic nibble_bus_oe_n,                // low while driving
  input wire logic [3:0] strap_id_inputs,      // identifier straps
  output logic core_write_stb,                 // one-cycle write to core/registers
  output logic core_read_stb,                  // one-cycle read request
  output logic core_space,                     // 1 flash core, 0 register space
  output logic [19:0] core_addr,               // decoded address
  output logic [7:0] core_wdata,               // write data or command byte
  input wire logic [7:0] core_rdata            // read data, valid after read strobe
);
  // ==========================================================
  // elaboration checks
  initial begin
    if (READ_BYTES != 1) begin
      $error("only single-byte transfers are supported");
    end
  end
  // ==========================================================
  // state
  typedef struct packed {
    nibble_port_pkg::cycle_state_e st; // cycle state
    logic is_write;                    // start code was a write
    logic [2:0] cnt;                   // nibble counter inside a field
    logic [27:0] addr;                 // address shift register
    logic [7:0] data;                  // write or read data byte
    logic [3:0] out;                   // bus drive value
    logic oe_n;                        // bus enable, low drives
    logic wr_stb;                      // write strobe to core
    logic rd_stb;                      // read strobe to core
    logic space;                       // latched space select
    logic [19:0] caddr;                // latched decoded address
  } port_state_s;
  port_state_s cur_ff;
  port_state_s nxt_ff;
  logic [19:0] dec_addr; // decoded address of the shift register
  logic dec_space;       // decoded space select
  // ==========================================================
  // address decode
  nibble_addr_decode #(
    .SMALL_DENSITY(SMALL_DENSITY)
  ) u_decode (
    .raw_addr(cur_ff.addr),
    .local_addr(dec_addr),
    .core_space(dec_space)
  );
  // ==========================================================
  // cycle sequencer
  always_comb begin
    nxt_ff = cur_ff;
    nxt_ff.wr_stb = 1'b0;
    nxt_ff.rd_stb = 1'b0;
    nxt_ff.oe_n = 1'b1;
    nxt_ff.out = nibble_port_pkg::TURN_ONES;
    if (!frame_strobe_n) begin
      // strobe low always floats and restarts; the core is untouched,
      // so an operation already handed over keeps running
      nxt_ff.st = nibble_port_pkg::ST_START; // R08 R09
      nxt_ff.cnt = 3'h0;
      // the last start nibble seen while low wins
      nxt_ff.is_write = (nibble_bus_in == nibble_port_pkg::START_MEM_WRITE); // R14
      if (nibble_bus_in != nibble_port_pkg::START_MEM_WRITE &&
          nibble_bus_in != nibble_port_pkg::START_MEM_READ) begin
        nxt_ff.st = nibble_port_pkg::ST_IDLE;
      end
    end else begin
      case (cur_ff.st)
        nibble_port_pkg::ST_IDLE: begin
          // wait for a strobe; nothing decoded here
          nxt_ff.st = nibble_port_pkg::ST_IDLE; // R17
        end
        nibble_port_pkg::ST_START: begin
          // strobe has risen: this nibble is the id select
          if (nibble_bus_in == strap_id_inputs) begin
            nxt_ff.st = nibble_port_pkg::ST_ADDR; // R13
          end else begin
            nxt_ff.st = nibble_port_pkg::ST_IDLE;
          end
          nxt_ff.cnt = 3'h0;
        end
        nibble_port_pkg::ST_ADDR: begin
          // most significant nibble first
          nxt_ff.addr = {cur_ff.addr[23:0], nibble_bus_in};
          nxt_ff.cnt = cur_ff.cnt + 3'h1;
          if (cur_ff.cnt == 3'(nibble_port_pkg::ADDR_NIBBLES - 1)) begin
            nxt_ff.st = nibble_port_pkg::ST_SIZE;
          end
        end
        nibble_port_pkg::ST_SIZE: begin
          nxt_ff.cnt = 3'h0;
          nxt_ff.caddr = dec_addr;
          nxt_ff.space = dec_space;
          if (nibble_bus_in != nibble_port_pkg::SIZE_ONE_BYTE) begin
            // bad size: silent return to idle, bus stays floated
            nxt_ff.st = nibble_port_pkg::ST_IDLE; // R04
          end else if (cur_ff.is_write) begin
            // from here every nibble is taken as valid
            nxt_ff.st = nibble_port_pkg::ST_WDATA; // R06
          end else begin
            nxt_ff.st = nibble_port_pkg::ST_TAR;
            nxt_ff.rd_stb = 1'b1;
          end
        end
        nibble_port_pkg::ST_WDATA: begin
          // low nibble arrives first
          nxt_ff.data = {nibble_bus_in, cur_ff.data[7:4]}; // R15
          nxt_ff.cnt = cur_ff.cnt + 3'h1;
          if (cur_ff.cnt == 3'h1) begin
            // commit only once the last nibble is in, ahead of the sync;
            // the byte goes out unchecked, command or data alike
            nxt_ff.wr_stb = 1'b1; // R10 R11 R07
            nxt_ff.st = nibble_port_pkg::ST_TAR;
            nxt_ff.cnt = 3'h0;
          end
        end
        nibble_port_pkg::ST_TAR: begin
          // two turnaround clocks; device starts driving in the clock after the second
          nxt_ff.cnt = cur_ff.cnt + 3'h1;
          if (cur_ff.cnt == 3'h1) begin
            nxt_ff.st = nibble_port_pkg::ST_SYNC;
            nxt_ff.cnt = 3'h0;
            nxt_ff.oe_n = 1'b0;
            if (cur_ff.is_write) begin
              nxt_ff.out = nibble_port_pkg::READY_SYNC; // R16
            end else begin
              nxt_ff.out = nibble_port_pkg::WAIT_SYNC;
            end
          end
        end
        nibble_port_pkg::ST_SYNC: begin
          nxt_ff.oe_n = 1'b0;
          nxt_ff.cnt = cur_ff.cnt + 3'h1;
          if (cur_ff.is_write) begin
            // ready sync held one clock only; the ones driven next clock
            // are the whole turnaround, so going through the read-side
            // turnaround state here would drive ones for a second clock
            nxt_ff.st = nibble_port_pkg::ST_IDLE; // R16
          end else if (cur_ff.cnt == 3'(nibble_port_pkg::READ_WAIT_SYNCS - 1)) begin
            nxt_ff.out = nibble_port_pkg::READY_SYNC;
          end else if (cur_ff.cnt == 3'(nibble_port_pkg::READ_WAIT_SYNCS)) begin
            nxt_ff.st = nibble_port_pkg::ST_RDATA;
            nxt_ff.cnt = 3'h0;
            nxt_ff.data = core_rdata;
            nxt_ff.out = core_rdata[3:0];
          end else begin
            nxt_ff.out = nibble_port_pkg::WAIT_SYNC;
          end
        end
        nibble_port_pkg::ST_RDATA: begin
          nxt_ff.oe_n = 1'b0;
          nxt_ff.out = cur_ff.data[7:4];
          nxt_ff.st = nibble_port_pkg::ST_TBACK;
          // a multibyte read would wrap the low page bits here; with
          // one byte per cycle the exact address is always returned
          nxt_ff.caddr[nibble_port_pkg::PAGE_BITS-1:0] = '0; // R05
        end
        nibble_port_pkg::ST_TBACK: begin
          // drive ones one clock, then float and hand back the bus
          nxt_ff.oe_n = 1'b0;
          nxt_ff.out = nibble_port_pkg::TURN_ONES;
          nxt_ff.st = nibble_port_pkg::ST_IDLE;
          if (cur_ff.oe_n) begin
            nxt_ff.oe_n = 1'b1;
          end
        end
        default: begin
          nxt_ff.st = nibble_port_pkg::ST_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // state register
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cur_ff.st <= nibble_port_pkg::ST_IDLE; // R17
      cur_ff.is_write <= 1'b0;
      cur_ff.cnt <= 3'h0;
      cur_ff.addr <= 28'h0000000;
      cur_ff.data <= 8'h00;
      cur_ff.out <= 4'hF;
      cur_ff.oe_n <= 1'b1;
      cur_ff.wr_stb <= 1'b0;
      cur_ff.rd_stb <= 1'b0;
      cur_ff.space <= 1'b0;
      cur_ff.caddr <= 20'h00000;
    end else begin
      cur_ff <= nxt_ff;
    end
  end
  // ==========================================================
  // outputs; strobe low floats combinationally for the immediate release
  assign nibble_bus_out = cur_ff.out;
  assign nibble_bus_oe_n = cur_ff.oe_n | ~frame_strobe_n; // R08
  assign core_write_stb = cur_ff.wr_stb;
  assign core_read_stb = cur_ff.rd_stb;
  assign core_space = cur_ff.space;
  assign core_addr = cur_ff.caddr;
  assign core_wdata = cur_ff.data;
endmodule

// ===== logic/nibble_port_pkg.sv
// constants and types shared by the nibble bus flash port control logic
package nibble_port_pkg;
  // ==========================================================
  // field codes on the nibble bus
  localparam logic [3:0] START_MEM_READ = 4'hD;  // start code, memory read
  localparam logic [3:0] START_MEM_WRITE = 4'hE; // start code, memory write
  localparam logic [3:0] SIZE_ONE_BYTE = 4'h0;   // only legal transfer size
  localparam logic [3:0] READY_SYNC = 4'h0;      // ready sync nibble
  localparam logic [3:0] WAIT_SYNC = 4'h5;       // wait sync nibble
  localparam logic [3:0] TURN_ONES = 4'hF;       // turnaround value
  // ==========================================================
  // address layout
  localparam int ADDR_NIBBLES = 7;       // nibbles of address sent
  localparam int DECODE_BITS = 20;       // bits decoded, larger density
  localparam int SMALL_MASK_BIT = 19;    // top bit of fifth-last nibble
  localparam int SPACE_SELECT_BIT = 22;  // core (1) or register space (0)
  localparam int PAGE_BITS = 5;          // low bits wrapped for multibyte reads
  localparam logic [3:0] READ_WAIT_SYNCS = 4'h2; // wait syncs before ready
  // ==========================================================
  // cycle states, one-hot
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,  // waiting for framing strobe
    ST_START = 10'h002, // strobe low, tracking start nibble
    ST_CHIP_SELECT_ID_FIELD = 10'h004, // id select nibble; never entered, the id nibble is checked in ST_START
    ST_ADDR = 10'h008,  // seven address nibbles
    ST_SIZE = 10'h010,  // size nibble
    ST_WDATA = 10'h020, // two write data nibbles
    ST_TAR = 10'h040,   // host to device turnaround
    ST_SYNC = 10'h080,  // wait/ready sync output
    ST_RDATA = 10'h100, // low read data nibble, one clock
    ST_TBACK = 10'h200  // device to host turnaround
  } cycle_state_e;
endpackage

// ===== logic/nibble_addr_decode.sv
// address decode: density masking and core/register space select
module nibble_addr_decode #(
  parameter bit SMALL_DENSITY = 1'b0 // 1 selects the smaller density
) (
  input wire logic [27:0] raw_addr, // full 28-bit address as received
  output logic [19:0] local_addr,   // decoded offset within the part
  output logic core_space           // 1 core, 0 register space
);
  // ==========================================================
  // masking
  always_comb begin
    // upper nibbles are dropped whatever they carry
    local_addr = raw_addr[nibble_port_pkg::DECODE_BITS-1:0]; // R01
    if (SMALL_DENSITY) begin
      local_addr[nibble_port_pkg::SMALL_MASK_BIT] = 1'b0; // R02
    end
    core_space = raw_addr[nibble_port_pkg::SPACE_SELECT_BIT]; // R03
  end
endmodule

// ===== verif/host_model.sv
// host bus controller model: drives framing strobe and host nibbles
module host_model (
  input wire logic clock,         // bus clock
  output logic frame_strobe_n,    // framing strobe, active low
  output logic [3:0] host_nib,    // nibble the host drives
  output logic host_en            // high while the host owns the bus
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================
  // idle: strobe high, bus released
  initial begin
    frame_strobe_n = 1'b1;
    host_nib = 4'hF;
    host_en = 1'b0;
  end
  // the first nlow nibbles go with strobe low; the last of them is the start
  task automatic send(input logic [3:0] q[$], input int nlow);
    foreach (q[k]) begin
      @(negedge clock);
      frame_strobe_n = (k < nlow) ? 1'b0 : 1'b1;
      host_nib = q[k];
      host_en = 1'b1;
    end
  endtask
  // turnaround: ones for one clock, then let go so the device can answer
  task automatic turn();
    @(negedge clock);
    host_nib = 4'hF;
    @(negedge clock);
    host_en = 1'b0;
  endtask
endmodule

// ===== verif/nibble_port_asserts.sv
// protocol checker bound to the nibble bus flash port control
module nibble_port_asserts #(
  parameter bit SMALL_DENSITY = 1'b0 // mirrors the design's density choice
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic frame_strobe_n,
  input wire logic [3:0] nibble_bus_out,
  input wire logic nibble_bus_oe_n,
  input wire logic core_write_stb,
  input wire logic core_read_stb,
  input wire logic [19:0] core_addr,
  input wire logic [7:0] core_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================
  // properties
  float_on_frame_a: assert property (!frame_strobe_n |-> nibble_bus_oe_n)
    else $error("bus driven while strobe low");
  reset_quiet_a: assert property (disable iff (1'b0)
    sys_rst |=> nibble_bus_oe_n && !core_write_stb && !core_read_stb)
    else $error("activity during reset");
  idle_after_reset_a: assert property ($fell(sys_rst) |-> nibble_bus_oe_n [*3])
    else $error("bus driven right after reset");
  write_sync_a: assert property (core_write_stb |-> ##2 (!nibble_bus_oe_n &&
    nibble_bus_out == 4'h0) ##1 (nibble_bus_out == 4'hF) ##1 nibble_bus_oe_n)
    else $error("write acknowledge sequence wrong");
  write_start_a: assert property (core_write_stb |->
    !$past(frame_strobe_n, 12) && $past(frame_strobe_n, 11))
    else $error("write issued at wrong cycle");
  read_start_a: assert property (core_read_stb |->
    !$past(frame_strobe_n, 10) && $past(frame_strobe_n, 9))
    else $error("read issued at wrong cycle");
  read_data_a: assert property (core_read_stb |-> ##2 (nibble_bus_out == 4'h5) [*2]
    ##1 (nibble_bus_out == 4'h0) ##1 (nibble_bus_out == core_rdata[3:0])
    ##1 (nibble_bus_out == core_rdata[7:4]))
    else $error("read answer sequence wrong");
  small_mask_a: assert property ((core_write_stb || core_read_stb) |->
    !(SMALL_DENSITY && core_addr[19]))
    else $error("masked address bit set");
endmodule
bind nibble_bus_flash_port_control nibble_port_asserts #(.SMALL_DENSITY(SMALL_DENSITY)) u_chk (
  .clock(clock), .sys_rst(sys_rst), .frame_strobe_n(frame_strobe_n),
  .nibble_bus_out(nibble_bus_out), .nibble_bus_oe_n(nibble_bus_oe_n),
  .core_write_stb(core_write_stb), .core_read_stb(core_read_stb),
  .core_addr(core_addr), .core_rdata(core_rdata));

// ===== verif/tb_nibble_bus_flash_port_control.sv
// self-checking bench for the nibble bus flash port control
module tb_nibble_bus_flash_port_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic frame_strobe_n, host_en, nibble_bus_oe_n, core_write_stb, core_read_stb, core_space;
  logic [3:0] host_nib, nibble_bus_out, bus;
  logic [3:0] strap_id_inputs = 4'h0;
  logic [7:0] core_rdata = 8'h00;
  logic [7:0] core_wdata;
  logic [19:0] core_addr;
  logic [29:0] exq[$];  // expected core requests
  logic [23:0] rq[$];   // expected bus answers
  logic [23:0] resp = 24'h0;
  logic [29:0] got;
  logic drv = 1'b0;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  // pull-up keeps the released bus at ones
  assign bus = host_en ? host_nib : (!nibble_bus_oe_n ? nibble_bus_out : 4'hF);
  always #5 clock = ~clock;
  host_model host (.clock(clock), .frame_strobe_n(frame_strobe_n), .host_nib(host_nib),
    .host_en(host_en));
  nibble_bus_flash_port_control #(.SMALL_DENSITY(1'b1)) dut (.clock(clock),
    .sys_rst(sys_rst), .frame_strobe_n(frame_strobe_n), .nibble_bus_in(bus),
    .nibble_bus_out(nibble_bus_out), .nibble_bus_oe_n(nibble_bus_oe_n),
    .strap_id_inputs(strap_id_inputs), .core_write_stb(core_write_stb),
    .core_read_stb(core_read_stb), .core_space(core_space), .core_addr(core_addr),
    .core_wdata(core_wdata), .core_rdata(core_rdata));
  // ==========================================
  // comparison and verdict
  task automatic check_val(input logic [29:0] g, input logic [29:0] e);
    checks++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic complete_run();
    if (exq.size() != 0 || rq.size() != 0) num_errors++;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // one host cycle; cut > 0 stops early so the next strobe aborts it
  task automatic do_cycle(input bit wr, input logic [3:0] id, input logic [3:0] sz,
      input logic [27:0] a, input logic [7:0] d, input int nlow, input int cut);
    logic [3:0] q[$];
    repeat (nlow - 1) q.push_back(wr ? nibble_port_pkg::START_MEM_READ : 4'hE);
    q.push_back(wr ? nibble_port_pkg::START_MEM_WRITE : nibble_port_pkg::START_MEM_READ);
    q.push_back(id);
    for (int k = 6; k >= 0; k--) q.push_back(a[4*k +: 4]);
    q.push_back(sz);
    if (wr) begin
      q.push_back(d[3:0]);
      q.push_back(d[7:4]);
    end
    if (cut > 0) q = q[0:cut-1];
    // only a whole cycle with matching id and size zero is answered
    if (id === strap_id_inputs && sz === 4'h0 && cut == 0) begin
      exq.push_back({wr, a[22], a[19:0] & 20'h7FFFF, wr ? d : 8'h00});
      rq.push_back(wr ? 24'h00000F : {12'h550, core_rdata[3:0], core_rdata[7:4], 4'hF});
    end
    host.send(q, nlow);
    if (cut == 0) begin
      host.turn();
      repeat (8) @(negedge clock);
    end
  endtask
  // ==========================================
  // monitor: settled outputs are sampled at the falling edge
  always @(negedge clock) begin
    if (!sys_rst) begin
      if (core_write_stb === 1'b1 || core_read_stb === 1'b1) begin
        got = {core_write_stb, core_space, core_addr, core_write_stb ? core_wdata : 8'h00};
        if (exq.size() == 0) check_val(got, ~got);
        else check_val(got, exq.pop_front());
      end
      if (nibble_bus_oe_n === 1'b0) begin
        resp = {resp[19:0], nibble_bus_out};
        drv = 1'b1;
      end else if (drv) begin
        if (rq.size() == 0) check_val({6'h0, resp}, ~{6'h0, resp});
        else check_val({6'h0, resp}, {6'h0, rq.pop_front()});
        resp = 24'h0;
        drv = 1'b0;
      end
    end
  end
  // hang guard: the sequence needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  // ==========================================
  // main sequence
  initial begin
    logic [27:0] a;
    logic [7:0] d;
    void'($urandom(58406));
    @(negedge clock);
    strap_id_inputs = 4'($urandom());
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    for (int i = 0; i < 8; i++) begin
      a = 28'($urandom());
      d = 8'($urandom());
      core_rdata = 8'($urandom());
      do_cycle(1'b1, strap_id_inputs, 4'h0, a, d, 1, 0);
      do_cycle(1'b0, strap_id_inputs, 4'h0, a ^ 28'h0400000, d, 1 + i % 2, 0);
    end
    do_cycle(1'b1, ~strap_id_inputs, 4'h0, a, d, 1, 0);
    for (int s = 1; s < 16; s += 7) do_cycle(1'b1, strap_id_inputs, 4'(s), a, d, 1, 0);
    do_cycle(1'b0, strap_id_inputs, 4'h8, a, d, 1, 0);
    do_cycle(1'b1, strap_id_inputs, 4'h0, a, d, 1, 11);
    do_cycle(1'b1, strap_id_inputs, 4'h0, a, 8'hA5, 1, 0);
    complete_run();
  end
endmodule
